// File: rtl/icc_ctrl.v
// i2c controller control register logic with axi4-lite slave and simple master engine
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "icc_defines.vh"
module icc_ctrl #(
  parameter ADDR_W = 32
) (
  input  wire              clk,
  input  wire              srst,
  input  wire              ce,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              slaveActive,
  input  wire              sclIn,
  output reg               sclOut,
  output reg               sclOe,
  input  wire              sdaIn,
  output reg               sdaOut,
  output reg               sdaOe,
  output reg               irq
);
  localparam S_IDLE = 5'h01;
  localparam S_STRT = 5'h02;
  localparam S_BITS = 5'h04;
  localparam S_HOLD = 5'h08;
  localparam S_STOP = 5'h10;

  reg [7:0]  ctl_r;
  reg [15:0] baud_r;
  reg [15:0] baudCnt_r;
  reg [`ICC_EV_W-1:0] irqSt_r;
  reg [`ICC_EV_W-1:0] irqMsk_r;
  reg [7:0]  dataHold_r;
  reg        dataFull_r;
  reg [7:0]  rxData_r;
  reg        rxFull_r;
  reg        arbLost_r;
  reg [4:0]  state_r;
  reg [1:0]  phase_r;
  reg [3:0]  bitCnt_r;
  reg [7:0]  shift_r;
  reg        txByte_r;
  reg        readDir_r;
  reg        sdaDrvLow_r;
  reg        sclDrvLow_r;
  reg        awHeld_r;
  reg        wHeld_r;
  reg [ADDR_W-1:0] awAddr_r;
  reg [31:0] wData_r;
  reg [3:0]  wStrb_r;
  reg [1:0]  sclSync_r;
  reg [1:0]  sdaSync_r;
  wire       sclF;
  wire       sdaF;

  // pins cross two flip-flops; only the second stage feeds the filters
  always @(posedge clk) begin
    if (srst) begin
      sclSync_r <= 2'h3;
      sdaSync_r <= 2'h3;
    end else if (ce) begin
      sclSync_r <= {sclSync_r[0], sclIn};
      sdaSync_r <= {sdaSync_r[0], sdaIn};
    end
  end

  icc_glitch_filter u_sclFilt (
    .clk  (clk),
    .srst (srst),
    .ce   (ce),
    .en   (ctl_r[`ICC_CTL_FILT]),
    .din  (sclSync_r[1]),
    .dout (sclF)
  );
  icc_glitch_filter u_sdaFilt (
    .clk  (clk),
    .srst (srst),
    .ce   (ce),
    .en   (ctl_r[`ICC_CTL_FILT]),
    .din  (sdaSync_r[1]),
    .dout (sdaF)
  );

  // bus decode of the pending write and the offered read
  wire doWr   = awHeld_r && wHeld_r && !s_axi_bvalid;
  wire [29:0] wIdx = awAddr_r[31:2];
  wire [29:0] rIdx = s_axi_araddr[31:2];
  wire wrData = doWr && wStrb_r[0] && (wIdx == `ICC_DATA_IDX);
  wire wrCtl  = doWr && wStrb_r[0] && (wIdx == `ICC_CTL_IDX);
  wire wrSt   = doWr && wStrb_r[0] && (wIdx == `ICC_IRQST_IDX);
  wire wrMsk  = doWr && wStrb_r[0] && (wIdx == `ICC_IRQMSK_IDX);
  wire wrBaud = doWr && (wIdx == `ICC_BAUD_IDX);
  wire wrHit  = (wIdx == `ICC_DATA_IDX) || (wIdx == `ICC_CTL_IDX) ||
                (wIdx == `ICC_IRQST_IDX) || (wIdx == `ICC_IRQMSK_IDX) ||
                (wIdx == `ICC_BAUD_IDX) || (wIdx == `ICC_ISTAT_IDX);
  wire rdTake = s_axi_arvalid && s_axi_arready;
  wire rdIst  = rdTake && (rIdx == `ICC_ISTAT_IDX);
  wire rdData = rdTake && (rIdx == `ICC_DATA_IDX);

  // enable as seen after this cycle's write
  wire enNow  = ctl_r[`ICC_CTL_EN];
  wire enNext = wrCtl ? wData_r[`ICC_CTL_EN] : enNow;
  // empty flag only meaningful while enabled
  wire txEmpty = enNow && !dataFull_r;

  // baud generator: quarter-bit ticks, or free timer when disabled
  // timer mode only while disabled
  wire baudRun  = enNow || ctl_r[`ICC_CTL_BAUD_TIMER_IRQ_REQUEST];
  wire baudTick = baudRun && (baudCnt_r == 16'h0001);
  always @(posedge clk) begin
    if (srst)
      baudCnt_r <= `ICC_BAUD_RST;
    else if (ce) begin
      if (!baudRun || baudTick)
        baudCnt_r <= baud_r;
      else if (baudCnt_r == 16'h0000)
        baudCnt_r <= 16'hffff; // zero reload counts as 10000h
      else
        baudCnt_r <= baudCnt_r - 16'h0001;
    end
  end

  // engine decisions at a byte boundary
  wire atEnd   = (phase_r == `ICC_LAST_PHASE);
  wire byteEnd = state_r[2] && atEnd && (bitCnt_r == `ICC_ACK_BIT);
  wire goTx    = !readDir_r && dataFull_r;
  wire goRx    = readDir_r && !rxFull_r;
  // sampling point: scl high, third quarter
  wire sampleNow = baudTick && state_r[2] && (phase_r == 2'h2);
  wire ackBit    = (bitCnt_r == `ICC_ACK_BIT);
  wire releasedTx = txByte_r && !ackBit && shift_r[7];
  // we left sda high but the bus shows low
  wire arbHit = sampleNow && releasedTx && !sdaF;

  // hardware clears of the request bits
  wire stopDone  = baudTick && state_r[4] && atEnd;
  wire startDone = baudTick && state_r[1] && atEnd;
  wire nakDone   = baudTick && state_r[2] && atEnd && ackBit && !txByte_r;
  wire startSlv  = ctl_r[`ICC_CTL_START] && slaveActive;

  // control register
  always @(posedge clk) begin
    if (srst)
      ctl_r <= `ICC_CTL_RST;
    else if (ce) begin
      if (wrCtl) begin
        ctl_r[`ICC_CTL_EN]   <= wData_r[`ICC_CTL_EN];
        ctl_r[`ICC_CTL_BAUD_TIMER_IRQ_REQUEST] <= wData_r[`ICC_CTL_BAUD_TIMER_IRQ_REQUEST];
        ctl_r[`ICC_CTL_TXI]  <= wData_r[`ICC_CTL_TXI];
        ctl_r[`ICC_CTL_FILT] <= wData_r[`ICC_CTL_FILT];
      end
      // flush is a strobe, never stored
      ctl_r[`ICC_CTL_FLUSH] <= 1'b0;
      // start: write one sets, hardware clears
      if (!enNext)
        ctl_r[`ICC_CTL_START] <= 1'b0;
      else if (wrCtl && wData_r[`ICC_CTL_START])
        ctl_r[`ICC_CTL_START] <= 1'b1;
      else if (startDone || startSlv || arbHit)
        ctl_r[`ICC_CTL_START] <= 1'b0;
      // stop: write one sets, hardware clears
      if (!enNext)
        ctl_r[`ICC_CTL_STOP] <= 1'b0;
      else if (wrCtl && wData_r[`ICC_CTL_STOP])
        ctl_r[`ICC_CTL_STOP] <= 1'b1;
      else if (stopDone || slaveActive || arbHit)
        ctl_r[`ICC_CTL_STOP] <= 1'b0;
      // nak: write one sets, cleared once sent
      if (!enNext)
        ctl_r[`ICC_CTL_NAK] <= 1'b0;
      else if (wrCtl && wData_r[`ICC_CTL_NAK])
        ctl_r[`ICC_CTL_NAK] <= 1'b1;
      else if (nakDone && ctl_r[`ICC_CTL_NAK])
        ctl_r[`ICC_CTL_NAK] <= 1'b0;
    end
  end

  // other software registers
  always @(posedge clk) begin
    if (srst) begin
      baud_r   <= `ICC_BAUD_RST;
      irqMsk_r <= `ICC_MSK_RST;
    end else if (ce) begin
      if (wrBaud && wStrb_r[0])
        baud_r[7:0] <= wData_r[7:0];
      if (wrBaud && wStrb_r[1])
        baud_r[15:8] <= wData_r[15:8];
      if (wrMsk)
        irqMsk_r <= wData_r[`ICC_EV_W-1:0];
    end
  end

  // events; set wins over a write-one clear in the same cycle
  wire [`ICC_EV_W-1:0] evSet;
  // empty condition raises an event only with its enable
  assign evSet[`ICC_EV_TXE]  = txEmpty && ctl_r[`ICC_CTL_TXI];
  assign evSet[`ICC_EV_BYTE] = byteEnd && baudTick;
  assign evSet[`ICC_EV_ARB]  = arbHit || startSlv;
  assign evSet[`ICC_EV_BAUD] = baudTick && !enNow;
  wire [`ICC_EV_W-1:0] evClr = wrSt ? wData_r[`ICC_EV_W-1:0] : {`ICC_EV_W{1'b0}};
  always @(posedge clk) begin
    if (srst) begin
      irqSt_r <= {`ICC_EV_W{1'b0}};
      irq     <= 1'b0;
    end else if (ce) begin
      irqSt_r <= (irqSt_r & ~evClr) | evSet;
      irq     <= |(irqSt_r & irqMsk_r);
    end
  end

  // arbitration lost flag, read of status clears, new loss wins
  always @(posedge clk) begin
    if (srst)
      arbLost_r <= 1'b0;
    else if (ce) begin
      if (arbHit || startSlv)
        arbLost_r <= 1'b1; // lost arbitration, or slave owns the bus
      else if (rdIst || !enNow)
        arbLost_r <= 1'b0;
    end
  end

  // master engine: one tick is a quarter bit period
  always @(posedge clk) begin
    if (srst) begin
      state_r     <= S_IDLE;
      phase_r     <= 2'h0;
      bitCnt_r    <= 4'h0;
      shift_r     <= 8'h00;
      txByte_r    <= 1'b0;
      readDir_r   <= 1'b0;
      sdaDrvLow_r <= 1'b0;
      sclDrvLow_r <= 1'b0;
      dataHold_r  <= 8'h00;
      dataFull_r  <= 1'b0;
      rxData_r    <= 8'h00;
      rxFull_r    <= 1'b0;
    end else if (ce) begin
      // software load fills the holding register
      if (wrData) begin
        dataHold_r <= wData_r[7:0];
        dataFull_r <= 1'b1;
      end
      // flush empties it, which raises the empty flag
      if (wrCtl && wData_r[`ICC_CTL_FLUSH])
        dataFull_r <= 1'b0;
      if (rdData)
        rxFull_r <= 1'b0;
      if (!enNow || arbHit) begin
        // disabled or beaten: release both lines
        state_r     <= S_IDLE;
        phase_r     <= 2'h0;
        sdaDrvLow_r <= 1'b0;
        sclDrvLow_r <= 1'b0;
      end else if (baudTick) begin
        phase_r <= phase_r + 2'h1;
        case (state_r)
          S_IDLE: begin
            phase_r <= 2'h0;
            // start waits for a byte to send and a released clock line
            if (ctl_r[`ICC_CTL_START] && dataFull_r && !slaveActive && sclF)
              state_r <= S_STRT;
          end
          S_STRT: begin
            // release sda, raise scl, pull sda, pull scl
            case (phase_r)
              2'h0: sdaDrvLow_r <= 1'b0;
              2'h1: sclDrvLow_r <= 1'b0;
              2'h2: sdaDrvLow_r <= 1'b1;
              default: begin
                sclDrvLow_r <= 1'b1;
                shift_r     <= dataHold_r;
                readDir_r   <= dataHold_r[0];
                txByte_r    <= 1'b1;
                dataFull_r  <= wrData;
                bitCnt_r    <= 4'h0;
                state_r     <= S_BITS;
              end
            endcase
          end
          S_BITS: begin
            case (phase_r)
              2'h0: begin
                if (ackBit)
                  // acknowledge received bytes unless nak requested
                  sdaDrvLow_r <= !txByte_r && !ctl_r[`ICC_CTL_NAK];
                else
                  sdaDrvLow_r <= txByte_r && !shift_r[7];
              end
              2'h1: sclDrvLow_r <= 1'b0;
              2'h2: begin
                if (!ackBit && !txByte_r)
                  shift_r <= {shift_r[6:0], sdaF};
              end
              default: begin
                sclDrvLow_r <= 1'b1;
                if (!ackBit && txByte_r)
                  shift_r <= {shift_r[6:0], 1'b0};
                bitCnt_r <= bitCnt_r + 4'h1;
                if (ackBit) begin
                  bitCnt_r <= 4'h0;
                  if (!txByte_r) begin
                    rxData_r <= shift_r;
                    rxFull_r <= 1'b1;
                  end
                  state_r <= S_HOLD;
                end
              end
            endcase
          end
          S_HOLD: begin
            // scl held low until the next step is known
            phase_r <= 2'h0;
            if (ctl_r[`ICC_CTL_STOP])
              state_r <= S_STOP;
            // repeated start after the finished byte
            else if (ctl_r[`ICC_CTL_START] && dataFull_r)
              state_r <= S_STRT;
            else if (goTx) begin
              shift_r    <= dataHold_r;
              txByte_r   <= 1'b1;
              dataFull_r <= wrData;
              state_r    <= S_BITS;
            end else if (goRx) begin
              txByte_r <= 1'b0;
              state_r  <= S_BITS;
            end
          end
          S_STOP: begin
            // pull sda, raise scl, release sda
            case (phase_r)
              2'h0: sdaDrvLow_r <= 1'b1;
              2'h1: sclDrvLow_r <= 1'b0;
              2'h2: sdaDrvLow_r <= 1'b0;
              default: state_r <= S_IDLE;
            endcase
          end
          default: state_r <= S_IDLE;
        endcase
      end
    end
  end

  // open-drain pins: level always low, enable pulls
  always @(posedge clk) begin
    if (srst) begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
      sclOe  <= 1'b0;
      sdaOe  <= 1'b0;
    end else if (ce) begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
      sclOe  <= sclDrvLow_r;
      sdaOe  <= sdaDrvLow_r;
    end
  end

  // read data mux
  reg [31:0] rMux;
  reg        rHit;
  always @* begin
    rMux = 32'h00000000;
    rHit = 1'b1;
    case (rIdx)
      `ICC_DATA_IDX:   rMux[7:0] = rxData_r;
      `ICC_ISTAT_IDX: begin
        rMux[`ICC_IST_TX_HOLDING_EMPTY_FLAG] = txEmpty;
        rMux[`ICC_IST_RDRF] = rxFull_r;
        rMux[`ICC_IST_ARB]  = arbLost_r;
      end
      `ICC_CTL_IDX:    rMux[7:0] = ctl_r & ~(8'h01 << `ICC_CTL_FLUSH);
      `ICC_IRQST_IDX:  rMux[`ICC_EV_W-1:0] = irqSt_r;
      `ICC_IRQMSK_IDX: rMux[`ICC_EV_W-1:0] = irqMsk_r;
      `ICC_BAUD_IDX:   rMux[15:0] = baud_r;
      default:         rHit = 1'b0;
    endcase
  end

  // axi4-lite write: address and data in either order, one response
  always @(posedge clk) begin
    if (srst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ICC_RESP_OKAY;
      awHeld_r      <= 1'b0;
      wHeld_r       <= 1'b0;
      awAddr_r      <= {ADDR_W{1'b0}};
      wData_r       <= 32'h00000000;
      wStrb_r       <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_r      <= s_axi_awaddr;
        awHeld_r      <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_r      <= s_axi_wdata;
        wStrb_r      <= s_axi_wstrb;
        wHeld_r      <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWr) begin
        awHeld_r     <= 1'b0;
        wHeld_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrHit ? `ICC_RESP_OKAY : `ICC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // axi4-lite read: answer one cycle after the address is taken
  always @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `ICC_RESP_OKAY;
    end else if (ce) begin
      if (rdTake) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rMux;
        s_axi_rresp   <= rHit ? `ICC_RESP_OKAY : `ICC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // icc_ctrl
`default_nettype wire

// File: rtl/icc_defines.vh
// register map, field positions, reset values and timing counts of the i2c control block
`ifndef ICC_DEFINES_VH
`define ICC_DEFINES_VH
// register indices; byte address is four times the index
`define ICC_DATA_IDX    30'h0ffe240
`define ICC_ISTAT_IDX   30'h0ffe241
`define ICC_CTL_IDX     30'h0ffe242
`define ICC_IRQST_IDX   30'h0ffe250
`define ICC_IRQMSK_IDX  30'h0ffe251
`define ICC_BAUD_IDX    30'h0ffe252
// control register fields
`define ICC_CTL_EN      7
`define ICC_CTL_START   6
`define ICC_CTL_STOP    5
`define ICC_CTL_BAUD_TIMER_IRQ_REQUEST    4
`define ICC_CTL_TXI     3
`define ICC_CTL_NAK     2
`define ICC_CTL_FLUSH   1
`define ICC_CTL_FILT    0
// interrupt status register fields
`define ICC_IST_TX_HOLDING_EMPTY_FLAG    7
`define ICC_IST_RDRF    6
`define ICC_IST_ARB     2
// sticky event bits, same layout in status and mask
`define ICC_EV_TXE      0
`define ICC_EV_BYTE     1
`define ICC_EV_ARB      2
`define ICC_EV_BAUD     3
`define ICC_EV_W        4
// reset values
`define ICC_CTL_RST     8'h00
`define ICC_BAUD_RST    16'hffff
`define ICC_MSK_RST     4'h0
// axi responses
`define ICC_RESP_OKAY   2'h0
`define ICC_RESP_SLVERR 2'h2
// filter latency in system clock cycles
`define ICC_FILT_LAT    3
// last quarter-bit phase of a bit and index of the acknowledge bit after the eight data bits
`define ICC_LAST_PHASE  2'h3
`define ICC_ACK_BIT     4'h8
`endif

// File: rtl/icc_glitch_filter.v
// spike filter for one synchronised bus input
`timescale 1ns/1ps
`default_nettype none
module icc_glitch_filter (
  input  wire clk,
  input  wire srst,
  input  wire ce,
  input  wire en,
  input  wire din,
  output wire dout
);
  reg s0_r;
  reg s1_r;
  reg hold_r;

  // new level accepted only after two equal samples; one-cycle spikes never pass
  always @(posedge clk) begin
    if (srst) begin
      s0_r   <= 1'b1;
      s1_r   <= 1'b1;
      hold_r <= 1'b1;
    end else if (ce) begin
      s0_r <= din;
      s1_r <= s0_r;
      if (s0_r == s1_r)
        hold_r <= s1_r;
    end
  end

  // bypass when off; when on the path is three cycles longer
  assign dout = en ? hold_r : din;
endmodule // icc_glitch_filter
`default_nettype wire

// File: tb/icc_ctrl_chk.sv
// port assertions for the i2c control block
`timescale 1ns/1ps
`default_nettype none
module icc_ctrl_chk (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        sclOe,
  input wire logic        sdaOe,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // register writes and reads must be answered promptly, and answers held
  chk_bresp_soon: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  chk_rdata_soon: assert property (s_axi_arvalid && s_axi_arready
    |-> ##[1:2] s_axi_rvalid) else $error("read answer late");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data changed");
  chk_aw_refuse: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write taken while answer open");
  chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer open");
  // quiet pins and bus after reset
  chk_reset_quiet: assert property ($fell(srst) |-> !irq && !sclOe && !sdaOe &&
    !s_axi_bvalid && !s_axi_rvalid) else $error("not quiet after reset");
  // sda pulled while scl free is a start; scl must follow
  chk_start_form: assert property ($rose(sdaOe) && !sclOe |-> ##[1:40] sclOe)
    else $error("start without clock low");
endmodule // icc_ctrl_chk
bind icc_ctrl icc_ctrl_chk chk_u (.clk(clk), .srst(srst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sclOe(sclOe), .sdaOe(sdaOe),
  .irq(irq));
`default_nettype wire

// File: tb/icc_bus_slave.sv
// behavioural bus slave that acknowledges every byte
`timescale 1ns/1ps
`default_nettype none
module icc_bus_slave (
  input  wire logic sclLine,
  input  wire logic sdaLine,
  output var  logic sdaPull
);
  int bitCnt = 0;
  initial sdaPull = 1'b0;
  // start rearms the bit count
  always @(negedge sdaLine) if (sclLine === 1'b1) bitCnt = 0;
  always @(posedge sclLine) bitCnt = (bitCnt == 9) ? 1 : bitCnt + 1;
  // pull only through the ninth clock, then let the pull-up win
  always @(negedge sclLine) sdaPull = (bitCnt == 8);
endmodule // icc_bus_slave
`default_nettype wire

// File: tb/icc_ctrl_bench.sv
// self-checking bench for the i2c control block
`timescale 1ns/1ps
`default_nettype none
`include "icc_defines.vh"
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module icc_ctrl_bench;
  logic        clk = 1'b0, srst = 1'b1, slvAct = 1'b0;
  logic [31:0] awAddr = '0, wData = '0, arAddr = '0, rd, rData;
  logic        awV = 0, wV = 0, bRdy = 0, arV = 0, rRdy = 0;
  logic        awR, wR, bV, arR, rV, sclOe, sdaOe, sclO, sdaO, irq, slvPull;
  logic [1:0]  bResp, rResp, resp;
  wire         sclW, sdaW;
  int          errors = 0, nTests = 0;
  byte         evQ[$];
  // open-drain lines with pull-ups
  assign sclW = !(sclOe && !sclO);
  assign sdaW = !((sdaOe && !sdaO) || slvPull);
  initial forever #10 clk = ~clk;
  icc_ctrl dut_u (.clk(clk), .srst(srst), .ce(1'b1), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awV), .s_axi_awready(awR), .s_axi_wdata(wData), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wV), .s_axi_wready(wR), .s_axi_bresp(bResp), .s_axi_bvalid(bV),
    .s_axi_bready(bRdy), .s_axi_araddr(arAddr), .s_axi_arvalid(arV), .s_axi_arready(arR),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rV), .s_axi_rready(rRdy),
    .slaveActive(slvAct), .sclIn(sclW), .sclOut(sclO), .sclOe(sclOe), .sdaIn(sdaW),
    .sdaOut(sdaO), .sdaOe(sdaOe), .irq(irq));
  icc_bus_slave slv_u (.sclLine(sclW), .sdaLine(sdaW), .sdaPull(slvPull));
  // log start and stop conditions seen on the wires
  always @(negedge sdaW) if (sclW === 1'b1) evQ.push_back("S");
  always @(posedge sdaW) if (sclW === 1'b1) evQ.push_back("P");
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic hang();
    errors++;
    close_out();
  endtask
  // response ready is raised only after valid, so holds get exercised
  task automatic wr(input logic [29:0] idx, input logic [31:0] d);
    int i;
    awAddr <= {idx, 2'b00};
    wData <= d;
    awV <= 1'b1;
    wV <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (awV && awR) awV <= 1'b0;
      if (wV && wR) wV <= 1'b0;
      if (bV && bRdy) break;
      if (bV) bRdy <= 1'b1;
    end
    if (i == 50) hang();
    resp = bResp;
    bRdy <= 1'b0;
  endtask
  task automatic rdReg(input logic [29:0] idx);
    int i;
    arAddr <= {idx, 2'b00};
    arV <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (arV && arR) arV <= 1'b0;
      if (rV && rRdy) break;
      if (rV) rRdy <= 1'b1;
    end
    if (i == 50) hang();
    rd = rData;
    resp = rResp;
    rRdy <= 1'b0;
  endtask
  task automatic poll(input logic [29:0] idx, input logic [31:0] m, input logic [31:0] e);
    int i;
    for (i = 0; i < 300; i++) begin
      rdReg(idx);
      if ((rd & m) === e) break;
    end
    if (i == 300) hang();
  endtask
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    evQ.delete();
    rdReg(`ICC_CTL_IDX);
    `CHK(rd, 32'h0)
    rdReg(`ICC_BAUD_IDX);
    `CHK(rd, 32'hffff)
    rdReg(30'h10);
    `CHK(resp, `ICC_RESP_SLVERR)
    wr(`ICC_BAUD_IDX, 32'h2);
    `CHK(resp, `ICC_RESP_OKAY)
    wr(30'h10, 32'hff);
    `CHK(resp, `ICC_RESP_SLVERR)
    wr(`ICC_CTL_IDX, 32'h40);
    rdReg(`ICC_CTL_IDX);
    `CHK(rd, 32'h0)
    wr(`ICC_CTL_IDX, 32'h80);
    rdReg(`ICC_ISTAT_IDX);
    `CHK(rd[`ICC_IST_TX_HOLDING_EMPTY_FLAG], 1'b1)
    // start with no byte waiting must hold off
    wr(`ICC_CTL_IDX, 32'hc0);
    wr(`ICC_CTL_IDX, 32'h80);
    rdReg(`ICC_CTL_IDX);
    `CHK(rd, 32'hc0)
    `CHK(evQ.size(), 0)
    wr(`ICC_DATA_IDX, 32'ha0);
    poll(`ICC_CTL_IDX, 32'hff, 32'h80);
    `CHK(evQ.size(), 1)
    // stop and start together: stop first, start waits for data
    wr(`ICC_CTL_IDX, 32'he0);
    poll(`ICC_CTL_IDX, 32'h20, 32'h0);
    `CHK(evQ.size(), 2)
    `CHK(evQ[1], "P")
    `CHK(rd[`ICC_CTL_START], 1'b1)
    wr(`ICC_DATA_IDX, 32'ha2);
    poll(`ICC_CTL_IDX, 32'hff, 32'h80);
    `CHK(evQ.size(), 3)
    wr(`ICC_CTL_IDX, 32'ha0);
    poll(`ICC_CTL_IDX, 32'hff, 32'h80);
    `CHK(evQ.size(), 4)
    `CHK(evQ[3], "P")
    // start during a byte: repeated start with no stop between
    wr(`ICC_DATA_IDX, 32'ha4);
    wr(`ICC_CTL_IDX, 32'hc0);
    poll(`ICC_CTL_IDX, 32'hff, 32'h80);
    wr(`ICC_DATA_IDX, 32'h5a);
    wr(`ICC_CTL_IDX, 32'hc0);
    poll(`ICC_CTL_IDX, 32'hff, 32'h80);
    `CHK(evQ.size(), 6)
    `CHK(evQ[5], "S")
    wr(`ICC_CTL_IDX, 32'ha0);
    poll(`ICC_CTL_IDX, 32'hff, 32'h80);
    `CHK(evQ.size(), 7)
    // requests during a slave transfer
    slvAct <= 1'b1;
    wr(`ICC_CTL_IDX, 32'he0);
    rdReg(`ICC_CTL_IDX);
    `CHK(rd, 32'h80)
    rdReg(`ICC_ISTAT_IDX);
    `CHK(rd[`ICC_IST_ARB], 1'b1)
    rdReg(`ICC_ISTAT_IDX);
    `CHK(rd[`ICC_IST_ARB], 1'b0)
    slvAct <= 1'b0;
    wr(`ICC_DATA_IDX, 32'h55);
    rdReg(`ICC_ISTAT_IDX);
    `CHK(rd[`ICC_IST_TX_HOLDING_EMPTY_FLAG], 1'b0)
    wr(`ICC_CTL_IDX, 32'h82);
    rdReg(`ICC_ISTAT_IDX);
    `CHK(rd[`ICC_IST_TX_HOLDING_EMPTY_FLAG], 1'b1)
    rdReg(`ICC_CTL_IDX);
    `CHK(rd, 32'h80)
    // empty interrupt: gated, masked, unmasked, cleared
    wr(`ICC_IRQST_IDX, 32'hf);
    rdReg(`ICC_IRQST_IDX);
    `CHK(rd, 32'h0)
    wr(`ICC_CTL_IDX, 32'h88);
    rdReg(`ICC_IRQST_IDX);
    `CHK(rd[`ICC_EV_TXE], 1'b1)
    `CHK(irq, 1'b0)
    wr(`ICC_IRQMSK_IDX, 32'h1);
    rdReg(`ICC_IRQST_IDX);
    `CHK(irq, 1'b1)
    wr(`ICC_CTL_IDX, 32'h90);
    wr(`ICC_IRQST_IDX, 32'hf);
    rdReg(`ICC_IRQST_IDX);
    `CHK(rd, 32'h0)
    `CHK(irq, 1'b0)
    // timer mode raises the baud event while disabled
    wr(`ICC_CTL_IDX, 32'h10);
    wr(`ICC_IRQMSK_IDX, 32'h8);
    poll(`ICC_IRQST_IDX, 32'h8, 32'h8);
    rdReg(`ICC_IRQST_IDX);
    `CHK(irq, 1'b1)
    wr(`ICC_CTL_IDX, 32'h01);
    rdReg(`ICC_CTL_IDX);
    `CHK(rd, 32'h01)
    close_out();
  end
endmodule // icc_ctrl_bench
`default_nettype wire
